/* shared/hrg_defs.vh */
// Purpose: constants of the two-channel record gateway
// Assumes: byte n of a record sits in word n/4, lane n%4
// Notes:   offsets are byte addresses on the register bus, except HRG_OFF_MODDIAG and HRG_OFF_DIR, which give offset bits 7:4
`ifndef HRG_DEFS_VH
`define HRG_DEFS_VH

// bus answers
`define HRG_RESP_OKAY      2'b00
`define HRG_RESP_SLVERR    2'b10
`define HRG_RESP_DECERR    2'b11

// record windows, selected by address bits 11:8
`define HRG_REG_REQ0       4'h0
`define HRG_REG_RSP0       4'h1
`define HRG_REG_REQ1       4'h2
`define HRG_REG_RSP1       4'h3
`define HRG_REG_MISC       4'h4
`define HRG_REC_BYTES      8'hf0
// small records and control words inside the misc window
`define HRG_OFF_SYSDIAG    8'h00
`define HRG_OFF_MODDIAG    4'h1
`define HRG_OFF_DIR        4'h2
`define HRG_OFF_FEAT       8'h40
`define HRG_OFF_COMMIT     8'h50
`define HRG_OFF_STATUS     8'h54

// commit word fields
`define HRG_CMT_CH         0
`define HRG_CMT_LEN_LSB    8
// command record byte 0
`define HRG_CMD_COMPACT    0
`define HRG_CMD_SUCC       1

// processing state codes
`define HRG_PS_IDLE        8'h00
`define HRG_PS_BUSY        8'h01
`define HRG_PS_OK          8'h02
`define HRG_PS_ERR         8'h03
`define HRG_LAYOUT_TRANSP  8'h00

// directory record: rev, count, 80,81,82,83,148,149, profile rev, zeros
`define HRG_DIR_W0         32'h51_50_06_01
`define HRG_DIR_W1         32'h95_94_53_52
`define HRG_DIR_W2         32'h00_00_00_01
`define HRG_DIR_W3         32'h00_00_00_00
// feature record: succ+compact supported, no client management, max 240
`define HRG_FEAT_W0        32'h00_f0_00_03

// field device side
`define HRG_POLL_CMD       8'h03
`define HRG_CLK_HZ         25000000
`define HRG_RESV_MS        2000
`define HRG_POLL_MS        100
`define HRG_RESV_CYC       ((`HRG_CLK_HZ / 1000) * `HRG_RESV_MS)
`define HRG_POLL_CYC       ((`HRG_CLK_HZ / 1000) * `HRG_POLL_MS)

`endif

/* src/hrg_gateway.v */
// Purpose: two-channel command record gateway behind an AXI4-Lite slave
// Assumes: one client per channel; the field side unit frames and times out
// Notes:   commands stream out byte-wise, replies stream back byte-wise
`timescale 1ns/1ns
`default_nettype none
`include "hrg_defs.vh"

// Functional notes
// - last four bytes of the module diagnostic record always read zero
// - module diagnostic record is 16 bytes, first four mirror system record
// - read-only directory record 148, 13 bytes, record numbers and revisions
// - read-only feature record 149, 3 bytes, optional functions and max length
// - writable 240-byte request records 80 and 82 for channels 0 and 1
// - readable 240-byte response records 81 and 83 for channels 0 and 1
// - one transfer area per channel, no client tracking
// - response carries a processing state; only ok or error means current
// - reply holds field status bytes telling whether and which error
// - each committed command is forwarded to that channel's field device
// - commands in transparent or compact layout are both accepted
// - responses are always given in transparent layout
// - successive flag reserves channel for 2 s, suppressing command 3 polling
// - each further flagged command restarts the 2 s reservation
// - unflagged command or 2 s silence resumes cyclic command 3 polling
// - channel error details shown in response and module diagnostic record
module hrg_gateway #(
    parameter [25:0] RESV_CYC = `HRG_RESV_CYC,
    parameter [25:0] POLL_CYC = `HRG_POLL_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire [1:0]  fd_tx_valid,
    output wire [15:0] fd_tx_data,
    output wire [1:0]  fd_tx_last,
    input  wire [1:0]  fd_tx_ready,
    input  wire [1:0]  fd_rx_valid,
    input  wire [15:0] fd_rx_data,
    input  wire [1:0]  fd_rx_last,
    input  wire [1:0]  fd_rx_err,
    input  wire [7:0]  fd_rx_cls
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_SEND = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;

    ////////////////////////////////////////////////////////////////////////
    // bus slave state
    reg        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    reg [1:0]  bresp_q, rresp_q;
    reg [31:0] rdata_q, wdata_q;
    reg [11:0] awaddr_q;
    reg [3:0]  wstrb_q;
    reg [31:0] rd_d;
    reg [1:0]  rresp_d, bresp_d;
    reg [1:0]  req_we, commit;
    wire       wr_do = ~awready_q & ~wready_q & ~bvalid_q;
    wire [3:0] wreg  = awaddr_q[11:8];
    wire [7:0] woff  = awaddr_q[7:0];
    wire [3:0] rreg  = s_axi_araddr[11:8];
    wire [7:0] roff  = s_axi_araddr[7:0];
    wire [7:0] cmt_len = wdata_q[`HRG_CMT_LEN_LSB +: 8];
    wire [1:0] busy;
    wire [63:0] rd_req, rd_rsp;
    wire [15:0] proc_all, diag_err, diag_code;
    wire [1:0] resv_all;
    wire [31:0] sys_diag = {30'd0, |diag_err, |diag_err};
    // module diag: system copy, error bytes, codes, zero tail
    wire [127:0] mdiag_w = {32'h0000_0000, 16'h0000, diag_code, 16'h0000, diag_err, sys_diag};
    wire [127:0] dir_w   = {`HRG_DIR_W3, `HRG_DIR_W2, `HRG_DIR_W1, `HRG_DIR_W0};

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // write decode; record writes only below 240 bytes
    always @* begin
        req_we  = 2'b00;
        commit  = 2'b00;
        bresp_d = `HRG_RESP_OKAY;
        if (wreg == `HRG_REG_REQ0 && woff < `HRG_REC_BYTES) begin
            req_we[0] = 1'b1;
        end else if (wreg == `HRG_REG_REQ1 && woff < `HRG_REC_BYTES) begin
            req_we[1] = 1'b1;
        end else if (wreg == `HRG_REG_MISC && woff == `HRG_OFF_COMMIT) begin
            // a second command while one is open is refused
            if (cmt_len == 8'h00 || cmt_len > `HRG_REC_BYTES ||
                busy[wdata_q[`HRG_CMT_CH]] || wstrb_q[1:0] != 2'b11) begin
                bresp_d = `HRG_RESP_SLVERR;
            end else begin
                commit[wdata_q[`HRG_CMT_CH]] = wr_do; // one pulse, not while the address lingers
            end
        end else if (wreg <= `HRG_REG_MISC) begin
            bresp_d = `HRG_RESP_SLVERR; // read-only record or gap
        end else begin
            bresp_d = `HRG_RESP_DECERR;
        end
    end

    // read decode straight from the address; answer one cycle later
    always @* begin
        rd_d    = 32'h0000_0000;
        rresp_d = `HRG_RESP_OKAY;
        if (rreg == `HRG_REG_RSP0 && roff < `HRG_REC_BYTES) begin
            rd_d = rd_rsp[31:0];
        end else if (rreg == `HRG_REG_RSP1 && roff < `HRG_REC_BYTES) begin
            rd_d = rd_rsp[63:32];
        end else if (rreg == `HRG_REG_REQ0 && roff < `HRG_REC_BYTES) begin
            rd_d = rd_req[31:0];
        end else if (rreg == `HRG_REG_REQ1 && roff < `HRG_REC_BYTES) begin
            rd_d = rd_req[63:32];
        end else if (rreg == `HRG_REG_MISC && roff == `HRG_OFF_SYSDIAG) begin
            rd_d = sys_diag;
        end else if (rreg == `HRG_REG_MISC && roff[7:4] == `HRG_OFF_MODDIAG) begin
            rd_d = mdiag_w[{roff[3:2], 5'd0} +: 32];
        end else if (rreg == `HRG_REG_MISC && roff[7:4] == `HRG_OFF_DIR) begin
            rd_d = dir_w[{roff[3:2], 5'd0} +: 32];
        end else if (rreg == `HRG_REG_MISC && roff == `HRG_OFF_FEAT) begin
            rd_d = `HRG_FEAT_W0;
        end else if (rreg == `HRG_REG_MISC && roff == `HRG_OFF_STATUS) begin
            rd_d = {14'd0, resv_all, proc_all};
        end else if (rreg <= `HRG_REG_MISC) begin
            rresp_d = `HRG_RESP_SLVERR;
        end else begin
            rresp_d = `HRG_RESP_DECERR;
        end
    end

    // channel handshakes; address and data may come in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            {awready_q, wready_q, arready_q} <= 3'h7;
            {bvalid_q, rvalid_q} <= 2'h0;
            {bresp_q, rresp_q} <= {`HRG_RESP_OKAY, `HRG_RESP_OKAY};
            {awaddr_q, wstrb_q} <= 16'h0000;
            {wdata_q, rdata_q} <= 64'h0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awaddr_q  <= s_axi_awaddr;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q) begin
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                wready_q <= 1'b0;
            end
            if (wr_do) begin
                bvalid_q <= 1'b1;
                bresp_q  <= bresp_d;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
            if (s_axi_arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_d;
                rresp_q   <= rresp_d;
            end
            if (rvalid_q && s_axi_rready) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one transfer area and field sequencer per channel, no client ids
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_ch
            reg [31:0] req_mem [0:59];
            reg [31:0] rsp_mem [0:57];
            reg [3:0]  st_q;
            reg        pend_q, poll_q, txv_q, txl_q;
            reg [7:0]  txd_q, tx_idx_q, tx_len_q, cmd_len_q, rx_idx_q;
            reg [7:0]  proc_q, grp_q, code_q, last_q, st1_q, st2_q, len_q;
            reg [7:0]  derr_q, dcode_q;
            reg [25:0] resv_q, pcnt_q;
            integer    b;
            wire [5:0] rw  = roff[7:2];
            wire [5:0] ri  = rw - 6'd2;
            wire [31:0] tw = req_mem[tx_idx_q[7:2]];
            wire [7:0] tbyte = tw[{tx_idx_q[1:0], 3'b000} +: 8];
            wire [7:0] rxd = fd_rx_data[c*8 +: 8];
            wire [7:0] rdi = rx_idx_q - 8'd2;
            wire       reserved = (resv_q != 26'd0);

            assign busy[c] = pend_q | (st_q != ST_IDLE && !poll_q);
            assign rd_req[c*32 +: 32] = req_mem[rw];
            // response header words, then data, always transparent
            assign rd_rsp[c*32 +: 32] = (rw == 6'd0) ? {last_q, code_q, grp_q, proc_q} :
                                        (rw == 6'd1) ? {`HRG_LAYOUT_TRANSP, len_q,
                                                        st2_q, st1_q} :
                                        rsp_mem[ri];
            assign proc_all[c*8 +: 8]  = proc_q;
            assign diag_err[c*8 +: 8]  = derr_q;
            assign diag_code[c*8 +: 8] = dcode_q;
            assign resv_all[c]         = reserved;
            assign fd_tx_valid[c]      = txv_q;
            assign fd_tx_data[c*8 +: 8] = txd_q;
            assign fd_tx_last[c]       = txl_q;

            // request record, byte-lane writes; layout byte passes unchanged
            always @(posedge aclk) begin
                if (wr_do && req_we[c]) begin
                    for (b = 0; b < 4; b = b + 1) begin
                        if (wstrb_q[b]) begin
                            req_mem[woff[7:2]][b*8 +: 8] <= wdata_q[b*8 +: 8];
                        end
                    end
                end
            end

            // reply data into the response record, header kept apart
            always @(posedge aclk) begin
                if (st_q == ST_WAIT && !poll_q && fd_rx_valid[c] && !fd_rx_err[c] &&
                    rx_idx_q >= 8'd2 && rx_idx_q < `HRG_REC_BYTES) begin
                    rsp_mem[rdi[7:2]][{rdi[1:0], 3'b000} +: 8] <= rxd;
                end
            end

            // sequencer: client command first, polling only when unreserved
            always @(posedge aclk) begin
                if (!aresetn) begin
                    st_q <= ST_IDLE;
                    {pend_q, poll_q, txv_q, txl_q} <= 4'h0;
                    {txd_q, tx_idx_q, tx_len_q, cmd_len_q, rx_idx_q} <= 40'h0;
                    proc_q <= `HRG_PS_IDLE;
                    {grp_q, code_q, last_q, st1_q, st2_q, len_q, derr_q, dcode_q} <= 64'h0;
                    resv_q <= 26'd0;
                    pcnt_q <= POLL_CYC;
                end else begin
                    if (reserved) begin
                        resv_q <= resv_q - 26'd1; // silence ends it
                    end
                    if (pcnt_q != 26'd0) begin
                        pcnt_q <= pcnt_q - 26'd1;
                    end
                    if (commit[c]) begin
                        pend_q    <= 1'b1;
                        cmd_len_q <= cmt_len;
                        last_q    <= req_mem[0][15:8];
                        proc_q    <= `HRG_PS_BUSY;
                        if (req_mem[0][`HRG_CMD_SUCC]) begin
                            resv_q <= RESV_CYC;
                        end else begin
                            resv_q <= 26'd0;
                        end
                    end
                    case (st_q)
                        ST_IDLE: begin
                            tx_idx_q <= 8'h00;
                            rx_idx_q <= 8'h00;
                            if (pend_q) begin
                                pend_q   <= 1'b0;
                                poll_q   <= 1'b0;
                                tx_len_q <= cmd_len_q;
                                st_q     <= ST_SEND;
                            end else if (!reserved && pcnt_q == 26'd0 && !commit[c]) begin
                                poll_q   <= 1'b1;
                                tx_len_q <= 8'h01;
                                pcnt_q   <= POLL_CYC;
                                st_q     <= ST_SEND;
                            end
                        end
                        ST_SEND: begin
                            if (!txv_q || fd_tx_ready[c]) begin
                                if (tx_idx_q == tx_len_q) begin
                                    txv_q <= 1'b0;
                                    txl_q <= 1'b0;
                                    st_q  <= ST_WAIT;
                                end else begin
                                    txv_q    <= 1'b1;
                                    txd_q    <= poll_q ? `HRG_POLL_CMD : tbyte;
                                    txl_q    <= (tx_idx_q == tx_len_q - 8'd1);
                                    tx_idx_q <= tx_idx_q + 8'd1;
                                end
                            end
                        end
                        ST_WAIT: begin
                            if (fd_rx_valid[c]) begin
                                if (rx_idx_q != 8'hff) begin
                                    rx_idx_q <= rx_idx_q + 8'd1;
                                end
                                if (!poll_q && !fd_rx_err[c] && rx_idx_q == 8'd0) begin
                                    st1_q <= rxd;
                                end
                                if (!poll_q && !fd_rx_err[c] && rx_idx_q == 8'd1) begin
                                    st2_q <= rxd;
                                end
                                if (fd_rx_last[c]) begin
                                    st_q <= ST_IDLE;
                                    // poll replies never touch the client record
                                    if (!poll_q && fd_rx_err[c]) begin
                                        proc_q  <= `HRG_PS_ERR;
                                        grp_q   <= {fd_rx_cls[c*4 +: 4], 4'h0};
                                        code_q  <= rxd;
                                        len_q   <= 8'h00;
                                        derr_q  <= {fd_rx_cls[c*4 +: 4], 4'h0};
                                        dcode_q <= rxd;
                                    end else if (!poll_q) begin
                                        proc_q  <= st1_q[7] ? `HRG_PS_ERR : `HRG_PS_OK;
                                        grp_q   <= {6'd0, st1_q[7], st2_q[4]};
                                        code_q  <= 8'h00;
                                        len_q   <= (rx_idx_q < 8'd2) ? 8'h00 :
                                                   rx_idx_q - 8'd1;
                                        derr_q  <= {6'd0, st1_q[7], st2_q[4]};
                                        dcode_q <= 8'h00;
                                    end
                                end
                            end
                        end
                        default: begin
                            st_q <= ST_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* verification/hrg_gateway_asserts.sv */
// Purpose: port checks on the record gateway
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every gateway instance
`timescale 1ns/1ns
`default_nettype none
`include "hrg_defs.vh"
module hrg_gateway_asserts (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [1:0]  fd_tx_valid,
    input  wire logic [15:0] fd_tx_data,
    input  wire logic [1:0]  fd_tx_ready
);
default clocking dc @(posedge aclk); endclocking
default disable iff (!aresetn);
// read request taken this edge
wire logic ar_go = s_axi_arvalid && s_axi_arready;
////////////////////////////////////////
a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
a_read_answer: assert property (ar_go |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
a_diag_tail: assert property (
    ar_go && s_axi_araddr == 12'h41c |=> s_axi_rdata == 32'h0) else $error("diag tail set");
a_dir_word: assert property (
    ar_go && s_axi_araddr == 12'h420 |=> s_axi_rdata == `HRG_DIR_W0) else $error("bad dir");
a_feat_word: assert property (
    ar_go && s_axi_araddr == 12'h440 |=> s_axi_rdata == `HRG_FEAT_W0) else $error("bad feat");
a_unmapped_read: assert property (ar_go && s_axi_araddr[11:8] > 4'h4
    |=> s_axi_rresp == `HRG_RESP_DECERR) else $error("unmapped read accepted");
a_tx_stands: assert property (
    fd_tx_valid[0] && !fd_tx_ready[0] |=> fd_tx_valid[0] && $stable(fd_tx_data[7:0]))
    else $error("field byte dropped");
endmodule
bind hrg_gateway hrg_gateway_asserts u_chk (.*);
`default_nettype wire

/* verification/hrg_field_model.sv */
// Purpose: behavioural field unit for both channels
// Assumes: one-byte frame is a poll, longer frames are client commands
// Notes:   reply s1,s2,cmd,len; error mode gives one error beat
`timescale 1ns/1ns
`default_nettype none
module hrg_field_model (
    input  wire logic        aclk,
    input  wire logic [1:0]  tx_valid,
    input  wire logic [15:0] tx_data,
    input  wire logic [1:0]  tx_last,
    output var  logic [1:0]  tx_ready,
    output var  logic [1:0]  rx_valid,
    output var  logic [15:0] rx_data,
    output var  logic [1:0]  rx_last,
    output var  logic [1:0]  rx_err,
    output var  logic [7:0]  rx_cls,
    input  wire logic [1:0]  err_mode,
    output var  logic [15:0] poll_cnt
);
logic [7:0] n [2] = '{8'h0, 8'h0};
logic [7:0] cn [2];
logic [7:0] ln [2];
logic [2:0] bt [2] = '{3'h0, 3'h0};
logic [1:0] cyc = 2'h0;
initial begin
    {tx_ready, rx_valid, rx_last, rx_err} = 8'h0;
    {rx_data, rx_cls, poll_cnt} = 40'h0;
end
// ready stalls one cycle in four so the gateway must hold its byte
always @(posedge aclk) begin
    cyc <= cyc + 2'd1;
    for (int c = 0; c < 2; c++) begin
        rx_valid[c] <= 1'b0;
        rx_last[c] <= 1'b0;
        rx_err[c] <= 1'b0;
        rx_data[c*8 +: 8] <= ~rx_data[c*8 +: 8]; // idle line never holds a stale byte
        tx_ready[c] <= (cyc != 2'd0);
        if (tx_valid[c] && tx_ready[c]) begin
            n[c] <= tx_last[c] ? 8'd0 : n[c] + 8'd1;
            if (n[c] == 8'd1) cn[c] <= tx_data[c*8 +: 8];
            if (tx_last[c]) begin
                bt[c] <= 3'd1;
                ln[c] <= n[c] + 8'd1;
                if (n[c] == 8'd0) poll_cnt[c*8 +: 8] <= poll_cnt[c*8 +: 8] + 8'd1;
            end
        end
        if (bt[c] != 3'd0) bt[c] <= bt[c] + 3'd1;
        // four quiet cycles, then the reply beats
        if (bt[c] >= 3'd4) begin
            rx_valid[c] <= 1'b1;
            rx_last[c] <= (bt[c] == 3'd7) || err_mode[c];
            rx_err[c] <= err_mode[c];
            rx_cls[c*4 +: 4] <= 4'h5;
            rx_data[c*8 +: 8] <= bt[c] == 3'd4 ? (err_mode[c] ? 8'h84 : 8'h00) :
                bt[c] == 3'd5 ? 8'h40 : bt[c] == 3'd6 ? cn[c] : ln[c];
            if (err_mode[c]) bt[c] <= 3'd0;
        end
    end
end
endmodule
`default_nettype wire

/* verification/hrg_gateway_tb_top.sv */
// Purpose: self-checking bench for the record gateway
// Assumes: shortened reservation and poll counts
// Notes:   bus inputs change by non-blocking update after an edge
`timescale 1ns/1ns
`default_nettype none
`include "hrg_defs.vh"
module hrg_gateway_tb_top;
logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic [11:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, d;
logic [1:0]  em = 2'b10, r;
logic [7:0]  p;
logic [31:0] dir [4] = '{`HRG_DIR_W0, `HRG_DIR_W1, `HRG_DIR_W2, `HRG_DIR_W3};
wire  logic        awready, wready, bvalid, arready, rvalid;
wire  logic [1:0]  bresp, rresp, txv, txl, txr, rxv, rxl, rxe;
wire  logic [31:0] rdata;
wire  logic [15:0] txd, rxd, pc;
wire  logic [7:0]  rxc;
int          n_mismatch = 0, n_compared = 0, cyc = 0;
hrg_gateway #(.RESV_CYC(26'd200), .POLL_CYC(26'd50)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fd_tx_valid(txv), .fd_tx_data(txd),
    .fd_tx_last(txl), .fd_tx_ready(txr), .fd_rx_valid(rxv), .fd_rx_data(rxd),
    .fd_rx_last(rxl), .fd_rx_err(rxe), .fd_rx_cls(rxc));
hrg_field_model u_fd (.aclk(aclk), .tx_valid(txv), .tx_data(txd), .tx_last(txl),
    .tx_ready(txr), .rx_valid(rxv), .rx_data(rxd), .rx_last(rxl), .rx_err(rxe), .rx_cls(rxc),
    .err_mode(em), .poll_cnt(pc));
always #20 aclk = ~aclk;
// watchdog: the whole run needs under a thousand cycles
always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        n_mismatch++;
        complete_run();
    end
end
////////////////////////////////////////
task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
        n_mismatch++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
endtask
// answer ready raised a cycle late so the slave must hold a read answer; bvalid and bready rise together
task automatic wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
        begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
        begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
    join
    @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
endtask
task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
endtask
task automatic rc(input logic [11:0] a, input logic [31:0] m, e, input logic [1:0] re);
    rd(a);
    chk({r, d & m}, {re, e & m});
endtask
task automatic wc(input logic [11:0] a, input logic [31:0] v, input logic [1:0] re);
    wr(a, v);
    chk({r, 32'h0}, {re, 32'h0});
endtask
// one client per channel: fill the record, commit, then wait out busy
task automatic cmd(input logic c, input logic [7:0] b0, cn);
    wr({2'b0, c, 9'h0}, {16'h55aa, cn, b0});
    wr({2'b0, c, 9'h4}, 32'h04030201);
    wc(12'h450, {16'h0, 8'h08, 7'h0, c}, `HRG_RESP_OKAY);
    rc({2'b0, c, 9'h100}, 32'hff, `HRG_PS_BUSY, `HRG_RESP_OKAY);
    wc(12'h450, {16'h0, 8'h08, 7'h0, c}, `HRG_RESP_SLVERR);
    do rd(12'h454); while (d[c*8 +: 8] === `HRG_PS_BUSY);
endtask
task automatic okr(input logic c, input logic [7:0] cn);
    rc({2'b0, c, 9'h100}, '1, {cn, 16'h0, `HRG_PS_OK}, `HRG_RESP_OKAY);
    rc({2'b0, c, 9'h104}, '1, 32'h00024000, `HRG_RESP_OKAY);
    rc({2'b0, c, 9'h108}, 32'hffff, {16'h0, 8'h08, cn}, `HRG_RESP_OKAY);
endtask
////////////////////////////////////////
initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) rc(12'h420 + 12'(4 * i), '1, dir[i], `HRG_RESP_OKAY);
    rc(12'h440, '1, `HRG_FEAT_W0, `HRG_RESP_OKAY);
    wc(12'h420, 32'h0, `HRG_RESP_SLVERR);
    wc(12'h104, 32'h0, `HRG_RESP_SLVERR);
    rc(12'h500, 32'h0, 32'h0, `HRG_RESP_DECERR);
    wc(12'h450, 32'h0, `HRG_RESP_SLVERR);
    wc(12'h450, 32'h0000f100, `HRG_RESP_SLVERR);
    wr(12'h0ec, 32'hdeadbeef);
    rc(12'h0ec, '1, 32'hdeadbeef, `HRG_RESP_OKAY);
    // channel 1 field unit fails; compact layout command
    cmd(1'b1, 8'h01, 8'h0d);
    rc(12'h300, '1, {8'h0d, 8'h84, 8'h50, `HRG_PS_ERR}, `HRG_RESP_OKAY);
    rc(12'h304, 32'hffff0000, 32'h0, `HRG_RESP_OKAY);
    rc(12'h41c, '1, 32'h0, `HRG_RESP_OKAY);
    rc(12'h400, 32'h3, 32'h3, `HRG_RESP_OKAY);
    rc(12'h410, '1, 32'h3, `HRG_RESP_OKAY);
    rc(12'h414, 32'hff00, 32'h5000, `HRG_RESP_OKAY);
    rc(12'h418, 32'hff00, 32'h8400, `HRG_RESP_OKAY);
    // channel 0 reservation: hold, restart, lapse, explicit end
    cmd(1'b0, 8'h02, 8'h01);
    p = pc[7:0];
    okr(1'b0, 8'h01);
    repeat (120) @(posedge aclk);
    rc(12'h454, 32'h10000, 32'h10000, `HRG_RESP_OKAY);
    chk({26'h0, pc[7:0]}, {26'h0, p});
    cmd(1'b0, 8'h03, 8'h22);
    okr(1'b0, 8'h22);
    repeat (120) @(posedge aclk);
    chk({26'h0, pc[7:0]}, {26'h0, p});
    repeat (250) @(posedge aclk);
    rc(12'h454, 32'h10000, 32'h0, `HRG_RESP_OKAY);
    chk({33'h0, pc[7:0] != p}, 34'h1);
    cmd(1'b0, 8'h02, 8'h30);
    okr(1'b0, 8'h30);
    cmd(1'b0, 8'h00, 8'h31);
    rc(12'h454, 32'h10000, 32'h0, `HRG_RESP_OKAY);
    okr(1'b0, 8'h31);
    complete_run();
end
endmodule
`default_nettype wire
